// ==== design/vic_pkg.sv ====
// Purpose: Shared constants and bus carriers for the vectored irq controller
// Assumes: AHB-Lite slave, 32-bit data, word aligned single transfers
// Notes:   Offsets are byte addresses within a 4 KB window
package vic_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NSRC_DEF  = 512;
	localparam int PRIO_W    = 4;
	localparam int NLVL      = 16;
	localparam int LVL_W     = 5;
	localparam int NCH       = 2;
	localparam int CH_IRQ    = 0;
	localparam int CH_FIQ    = 1;
	localparam int WORD_BITS = 32;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [11:0] OFS_IRQVEC  = 12'h000;
	localparam logic [11:0] OFS_FIQVEC  = 12'h004;
	localparam logic [11:0] OFS_INSVC   = 12'h008;
	localparam logic [11:0] OFS_INTSTAT = 12'h00c;
	localparam logic [11:0] OFS_INTMASK = 12'h010;
	localparam logic [11:0] OFS_LEVEL   = 12'h014;
	// Raw status/set window 0x100..0x13c, one bit per source
	localparam logic [5:0]  RAW_PAGE    = 6'h04;
	// Per-source config window 0x800..0xffc, one word per source
	localparam int          CFG_SEL_BIT = 11;

	////////////////////////////////////////////////////////////////////////
	// Field layouts
	localparam int VEC_VALID_BIT = 31;
	localparam int VEC_PRIO_LSB  = 16;
	localparam int CFG_PRIO_LSB  = 0;
	localparam int CFG_FIQ_BIT   = 8;
	localparam int INSVC_FIQ_LSB = 16;
	localparam int LVL_FIQ_LSB   = 8;
	localparam int LVL_REQ_BIT   = 7;

	// Sticky event bits, same layout in status and mask
	localparam int EV_IRQ_ACK  = 0;
	localparam int EV_FIQ_ACK  = 1;
	localparam int EV_IRQ_EOI  = 2;
	localparam int EV_FIQ_EOI  = 3;
	localparam int EV_EOI_IDLE = 4;
	localparam int EV_W        = 5;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [PRIO_W-1:0] PRIO_RST = 4'hf;
	localparam logic [EV_W-1:0]   MASK_RST = 5'h00;

	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic        hdebug;
		logic [31:0] hwdata;
	} vic_ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} vic_ahb_rsp_s;

endpackage

// ==== design/vic_ctrl.sv ====
// Purpose: Vectored interrupt controller with nesting, fast and normal req
// Assumes: Sources are async levels, rising edge latches a pending bit
// Notes:   Debug-tagged reads have no side effects of any kind
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps

// What this block does
// - Vector register read changes interrupt handling state
// - Only functional reads cause state changes
// - Debug read returns vector without acknowledging
// - Same source cannot preempt its own routine, only a strictly higher level can
// - Vector and register methods nest identically
// - Fast and normal requests nest identically
// - Up to 512 sources, each prioritised and typed
// - Levels 0 to 15, zero is highest
// - Raw set write one makes source pending
// - Raw set write zero clears software pending
// - Functional vector read acknowledges top pending source
// - Any vector write ends interrupt, restores level
// - Ack and end complete by register access alone
module vic_ctrl #(
	parameter int NSRC = vic_pkg::NSRC_DEF
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	input  wire vic_pkg::vic_ahb_req_s ahbReq,
	output vic_pkg::vic_ahb_rsp_s      ahbRsp,
	input  wire logic [NSRC-1:0]       srcIn,
	output logic                       irqReq,
	output logic                       fiqReq,
	output logic                       interrupt
);
	import vic_pkg::*;

	localparam int IW     = $clog2(NSRC);
	localparam int NWORDS = NSRC / WORD_BITS;

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [NSRC-1:0]              sync1;
		logic [NSRC-1:0]              sync2;
		logic [NSRC-1:0]              srcPrev;
		logic [NSRC-1:0]              hwPend;
		logic [NSRC-1:0]              swPend;
		logic [NSRC-1:0]              fiqSel;
		logic [NSRC-1:0][PRIO_W-1:0]  prio;
		logic [NCH-1:0][NLVL-1:0]     inSvc;
		logic [EV_W-1:0]              stat;
		logic [EV_W-1:0]              mask;
		logic                         wrPend;
		logic [11:0]                  wrAddr;
		logic [31:0]                  rdata;
		logic                         rdy;
		logic                         irq;
		logic                         fiq;
		logic                         intr;
	} vic_state_s;

	vic_state_s stateReg;
	vic_state_s stateNext;

	////////////////////////////////////////////////////////////////////////
	// Combinational next state
	logic [NSRC-1:0]             pendAll;
	logic [NCH-1:0]              found;
	logic [NCH-1:0][LVL_W-1:0]   bestLvl;
	logic [NCH-1:0][IW-1:0]      bestIdx;
	logic [NCH-1:0][LVL_W-1:0]   curLvl;
	logic [NCH-1:0]              fwd;
	logic [NCH-1:0][31:0]        vecVal;
	logic [NCH-1:0][NLVL-1:0]    ackBit;
	logic [NCH-1:0][NLVL-1:0]    eoiBit;
	logic [NSRC-1:0]             ackClr;
	logic [EV_W-1:0]             events;
	logic [EV_W-1:0]             w1c;
	logic                        acc;
	logic                        rdAcc;
	logic                        funcRd;
	logic [11:0]                 aAddr;
	logic [31:0]                 rd;
	logic [IW-1:0]               cfgIdx;
	logic [CFG_SEL_BIT-3:0]      cfgFull;
	logic [CFG_SEL_BIT-3:0]      wrFull;

	always_comb begin
		stateNext = stateReg;
		pendAll   = stateReg.hwPend | stateReg.swPend;
		found     = '0;
		bestLvl   = '0;
		bestIdx   = '0;
		curLvl    = '0;
		fwd       = '0;
		vecVal    = '0;
		ackBit    = '0;
		eoiBit    = '0;
		ackClr    = '0;
		events    = '0;
		w1c       = '0;
		rd        = '0;
		aAddr     = ahbReq.haddr[11:0];
		// Full window index, so slots past the last source alias nothing
		cfgFull   = aAddr[CFG_SEL_BIT-1:2];
		cfgIdx    = cfgFull[IW-1:0];
		wrFull    = stateReg.wrAddr[CFG_SEL_BIT-1:2];
		acc       = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];
		rdAcc     = acc & ~ahbReq.hwrite;
		funcRd    = rdAcc & ~ahbReq.hdebug;

		// Source synchronisers and edge latch
		stateNext.sync1   = srcIn;
		stateNext.sync2   = stateReg.sync1;
		stateNext.srcPrev = stateReg.sync2;

		// Per channel: winner, level in service, vector word
		for (int ch = 0; ch < NCH; ch++) begin
			bestLvl[ch] = LVL_W'(NLVL);
			curLvl[ch]  = LVL_W'(NLVL);
			// Descending scan with <= gives lowest index on ties
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (pendAll[i] && (stateReg.fiqSel[i] == ch[0]) &&
				    ({1'b0, stateReg.prio[i]} <= bestLvl[ch])) begin
					found[ch]   = 1'b1;
					bestLvl[ch] = {1'b0, stateReg.prio[i]};
					bestIdx[ch] = IW'(i);
				end
			end
			// Lowest set in-service bit is the running level
			for (int l = NLVL - 1; l >= 0; l--) begin
				if (stateReg.inSvc[ch][l]) begin
					curLvl[ch] = LVL_W'(l);
					eoiBit[ch] = '0;
					eoiBit[ch][l] = 1'b1;
				end
			end
			// Strictly higher level preempts, so a source acked earlier
			// cannot preempt its own routine again while that level is in service
			fwd[ch] = found[ch] && (bestLvl[ch] < curLvl[ch]);
			vecVal[ch][VEC_VALID_BIT] = fwd[ch];
			vecVal[ch][VEC_PRIO_LSB +: PRIO_W] = bestLvl[ch][PRIO_W-1:0];
			vecVal[ch][IW-1:0] = bestIdx[ch];
		end

		////////////////////////////////////////////////////////////////////
		// Address phase: reads are answered from a flop in the data phase
		if (rdAcc) begin
			if (aAddr[CFG_SEL_BIT]) begin
				if (32'(cfgFull) < NSRC) begin
					rd[CFG_PRIO_LSB +: PRIO_W] = stateReg.prio[cfgIdx];
					rd[CFG_FIQ_BIT] = stateReg.fiqSel[cfgIdx];
				end
			end else if (aAddr[11:6] == RAW_PAGE) begin
				for (int k = 0; k < NWORDS; k++) begin
					if (aAddr[5:2] == 4'(k))
						rd = pendAll[k*WORD_BITS +: WORD_BITS];
				end
			end else begin
				unique case (aAddr)
					OFS_IRQVEC:  rd = vecVal[CH_IRQ];
					OFS_FIQVEC:  rd = vecVal[CH_FIQ];
					OFS_INSVC: begin
						rd[NLVL-1:0] = stateReg.inSvc[CH_IRQ];
						rd[INSVC_FIQ_LSB +: NLVL] = stateReg.inSvc[CH_FIQ];
					end
					OFS_INTSTAT: rd[EV_W-1:0] = stateReg.stat;
					OFS_INTMASK: rd[EV_W-1:0] = stateReg.mask;
					OFS_LEVEL: begin
						rd[LVL_W-1:0] = curLvl[CH_IRQ];
						rd[LVL_REQ_BIT] = stateReg.irq;
						rd[LVL_FIQ_LSB +: LVL_W] = curLvl[CH_FIQ];
						rd[LVL_FIQ_LSB + LVL_REQ_BIT] = stateReg.fiq;
					end
					default: rd = '0;
				endcase
			end
			stateNext.rdata = rd;
		end

		// Functional vector read acknowledges; debug read skips this
		for (int ch = 0; ch < NCH; ch++) begin
			if (funcRd && fwd[ch] &&
			    aAddr == (ch == CH_IRQ ? OFS_IRQVEC : OFS_FIQVEC)) begin
				ackBit[ch][bestLvl[ch][PRIO_W-1:0]] = 1'b1;
				ackClr[bestIdx[ch]] = 1'b1;
				events[ch == CH_IRQ ? EV_IRQ_ACK : EV_FIQ_ACK] = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////
		// Data phase of a write
		if (stateReg.wrPend) begin
			if (stateReg.wrAddr[CFG_SEL_BIT]) begin
				if (32'(wrFull) < NSRC) begin
					stateNext.prio[wrFull[IW-1:0]] =
						ahbReq.hwdata[CFG_PRIO_LSB +: PRIO_W];
					stateNext.fiqSel[wrFull[IW-1:0]] =
						ahbReq.hwdata[CFG_FIQ_BIT];
				end
			end else if (stateReg.wrAddr[11:6] == RAW_PAGE) begin
				// Ones set, zeros clear the software pending bits
				for (int k = 0; k < NWORDS; k++) begin
					if (stateReg.wrAddr[5:2] == 4'(k))
						stateNext.swPend[k*WORD_BITS +: WORD_BITS] =
							ahbReq.hwdata;
				end
			end else begin
				unique case (stateReg.wrAddr)
					OFS_IRQVEC, OFS_FIQVEC: begin
						for (int ch = 0; ch < NCH; ch++) begin
							if (stateReg.wrAddr == (ch == CH_IRQ ?
							    OFS_IRQVEC : OFS_FIQVEC)) begin
								if (curLvl[ch] == LVL_W'(NLVL)) begin
									events[EV_EOI_IDLE] = 1'b1;
								end else begin
									// Any data value ends the service
									events[ch == CH_IRQ ?
										EV_IRQ_EOI : EV_FIQ_EOI] = 1'b1;
								end
							end else begin
								eoiBit[ch] = '0;
							end
						end
					end
					OFS_INTSTAT: w1c = ahbReq.hwdata[EV_W-1:0];
					OFS_INTMASK: stateNext.mask = ahbReq.hwdata[EV_W-1:0];
					default: w1c = '0;
				endcase
			end
		end
		if (!(stateReg.wrPend && !stateReg.wrAddr[CFG_SEL_BIT] &&
		      (stateReg.wrAddr == OFS_IRQVEC ||
		       stateReg.wrAddr == OFS_FIQVEC)))
			eoiBit = '0;

		// Release on end, then mark a new ack; both methods share this
		for (int ch = 0; ch < NCH; ch++) begin
			stateNext.inSvc[ch] =
				(stateReg.inSvc[ch] & ~eoiBit[ch]) | ackBit[ch];
		end

		// A source edge in the ack cycle stays pending
		stateNext.hwPend = (stateReg.hwPend & ~ackClr) |
			(stateReg.sync2 & ~stateReg.srcPrev);

		stateNext.wrPend = acc & ahbReq.hwrite;
		stateNext.wrAddr = aAddr;
		stateNext.rdy    = 1'b1;

		// Sticky events: a set wins over a same-cycle clear
		stateNext.stat = (stateReg.stat & ~w1c) | events;
		stateNext.intr = |(stateNext.stat & stateNext.mask);

		// Requests follow this cycle's view of pending and service, dropped in an ack cycle
		stateNext.irq = fwd[CH_IRQ] & ~(|ackBit[CH_IRQ]);
		stateNext.fiq = fwd[CH_FIQ] & ~(|ackBit[CH_FIQ]);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stateReg      <= '0;
			stateReg.prio <= {NSRC{PRIO_RST}};
			stateReg.mask <= MASK_RST;
			stateReg.rdy  <= 1'b1;
		end else begin
			stateReg <= stateNext;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops except hresp, which is tied low
	assign ahbRsp.hrdata    = stateReg.rdata;
	assign ahbRsp.hreadyout = stateReg.rdy;
	assign ahbRsp.hresp     = 1'b0;
	assign irqReq           = stateReg.irq;
	assign fiqReq           = stateReg.fiq;
	assign interrupt        = stateReg.intr;

endmodule // vic_ctrl

// ==== bench/vic_ctrl_monitor.sv ====
// Purpose: Port checker for vic_ctrl
// Assumes: Zero-wait slave, hdebug tags debug reads
// Notes:   Bound into every vic_ctrl
`timescale 1ns/100ps
module vic_ctrl_monitor #(
	parameter int NSRC = vic_pkg::NSRC_DEF
) (
	input wire logic                  clk_sys,
	input wire logic                  reset_n,
	input wire vic_pkg::vic_ahb_req_s ahbReq,
	input wire vic_pkg::vic_ahb_rsp_s ahbRsp,
	input wire logic [NSRC-1:0]       srcIn,
	input wire logic                  irqReq,
	input wire logic                  fiqReq,
	input wire logic                  interrupt
);
	import vic_pkg::*;
	logic tk, rd, rdI, rdF;
	assign tk = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];
	assign rd = tk & !ahbReq.hwrite;
	assign rdI = rd & (ahbReq.haddr[11:0] == OFS_IRQVEC);
	assign rdF = rd & (ahbReq.haddr[11:0] == OFS_FIQVEC);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	property p_rdy; ahbRsp.hreadyout && !ahbRsp.hresp; endproperty
	a_rdy: assert property (p_rdy) else $error("bus stalled");
	property p_hold; !rd |=> $stable(ahbRsp.hrdata); endproperty
	a_hold: assert property (p_hold) else $error("hrdata moved");
	property p_rst;
		disable iff (1'b0) !reset_n |=> !irqReq && !fiqReq && !interrupt;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	// Earlier transfers may still land, so exclude them
	property p_dbgI; rdI && ahbReq.hdebug && irqReq && !$past(tk) |=> irqReq;
	endproperty
	a_dbgI: assert property (p_dbgI) else $error("debug acked irq");
	property p_dbgF; rdF && ahbReq.hdebug && fiqReq && !$past(tk) |=> fiqReq;
	endproperty
	a_dbgF: assert property (p_dbgF) else $error("debug acked fiq");
	property p_valI;
		rdI && irqReq && !$past(tk) && !$past(tk, 2) |=> ahbRsp.hrdata[31];
	endproperty
	a_valI: assert property (p_valI) else $error("irq vector invalid");
	property p_valF;
		rdF && fiqReq && !$past(tk) && !$past(tk, 2) |=> ahbRsp.hrdata[31];
	endproperty
	a_valF: assert property (p_valF) else $error("fiq vector invalid");
	property p_int;
		$rose(interrupt) |-> $past(tk) || $past(tk, 2) || $past(tk, 3);
	endproperty
	a_int: assert property (p_int) else $error("stray interrupt");
	c_dbg: cover property (rdI && ahbReq.hdebug && irqReq);
	c_fiq: cover property (rdF && !ahbReq.hdebug && fiqReq);
	c_int: cover property ($rose(interrupt));
endmodule // vic_ctrl_monitor

bind vic_ctrl vic_ctrl_monitor #(.NSRC(NSRC)) mon_u (.clk_sys(clk_sys),
	.reset_n(reset_n), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .srcIn(srcIn),
	.irqReq(irqReq), .fiqReq(fiqReq), .interrupt(interrupt));

// ==== bench/vic_core_model.sv ====
// Purpose: Core taking fast and normal requests
// Assumes: Entry registered one cycle after request
// Notes:   Masks stand for the core's own disables
`timescale 1ns/100ps
module vic_core_model (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic irqReq,
	input  wire logic fiqReq,
	input  wire logic maskIrq,
	input  wire logic maskFiq,
	output logic      irqEntry,
	output logic      fiqEntry
);
	// Masked core never enters; handshake is done by registers alone
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			irqEntry <= 1'b0;
			fiqEntry <= 1'b0;
		end else begin
			irqEntry <= irqReq & !maskIrq;
			fiqEntry <= fiqReq & !maskFiq;
		end
	end
endmodule // vic_core_model

// ==== bench/vic_ctrl_bench.sv ====
// Purpose: Directed bench for vic_ctrl
// Assumes: 32 sources, AHB-Lite master tasks
// Notes:   Core masks itself around dummy handshake
`timescale 1ns/100ps
module vic_ctrl_bench;
	import vic_pkg::*;
	localparam int N = 32;
	logic clk_sys, reset_n, maskIrq, maskFiq, irqReq, fiqReq, interrupt;
	logic irqEntry, fiqEntry;
	logic [N-1:0] srcIn;
	logic [31:0] rd;
	vic_ahb_req_s drv, req;
	vic_ahb_rsp_s ahbRsp;
	int mismatches, checks;
	vic_ctrl #(.NSRC(N)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
		.ahbReq(req), .ahbRsp(ahbRsp), .srcIn(srcIn), .irqReq(irqReq),
		.fiqReq(fiqReq), .interrupt(interrupt));
	vic_core_model core_u (.clk_sys(clk_sys), .reset_n(reset_n),
		.irqReq(irqReq), .fiqReq(fiqReq), .maskIrq(maskIrq),
		.maskFiq(maskFiq), .irqEntry(irqEntry), .fiqEntry(fiqEntry));
	always_comb begin
		req = drv;
		req.hready = ahbRsp.hreadyout;
	end
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic xfer(input logic w, d, input logic [11:0] a,
		input logic [31:0] wd);
		drv.hsel <= 1'b1;
		drv.htrans <= HTRANS_NONSEQ;
		drv.haddr <= {20'h00000, a};
		drv.hwrite <= w;
		drv.hdebug <= d;
		do @(posedge clk_sys); while (ahbRsp.hreadyout !== 1'b1);
		drv.htrans <= HTRANS_IDLE;
		drv.hwdata <= wd;
		do @(posedge clk_sys); while (ahbRsp.hreadyout !== 1'b1);
		rd = ahbRsp.hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, 1'b0, a, d);
	endtask
	task automatic rdc(input string n, input logic [11:0] a,
		input logic [31:0] e, input logic d);
		xfer(1'b0, d, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic waitq(input bit f);
		for (int i = 0; i < 20 && (f ? fiqReq : irqReq) !== 1'b1; i++)
			@(posedge clk_sys);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		drv = '0;
		drv.hsize = 3'h2;
		srcIn = '0;
		maskIrq = 1'b0;
		maskFiq = 1'b0;
		reset_n = 1'b0;
		tick(10);
		reset_n <= 1'b1;
		tick(1);
		rdc("cfgRst", 12'h80c, 32'h0000000f, 0);
		rdc("maskRst", OFS_INTMASK, 32'h0, 0);
		rdc("unmapped", 12'h020, 32'h0, 0);
		wr(12'h80c, 32'h5);
		wr(12'h81c, 32'h2);
		wr(12'h824, 32'h101);
		wr(12'h800, 32'h0);
		// Slot past the last source must not alias source 0
		wr(12'h880, 32'h107);
		rdc("cfgOut", 12'h880, 32'h0, 0);
		rdc("cfgAlias", 12'h800, 32'h0, 0);
		rdc("cfgFiq", 12'h824, 32'h101, 0);
		srcIn[3] <= 1'b1;
		waitq(0);
		rdc("dbgVec", OFS_IRQVEC, 32'h80050003, 1);
		tick(2);
		chk("irqDbg", 1, irqReq);
		rdc("statDbg", OFS_INTSTAT, 32'h0, 0);
		chk("entry", 1, irqEntry);
		rdc("ack3", OFS_IRQVEC, 32'h80050003, 0);
		tick(2);
		chk("irqAck", 0, irqReq);
		rdc("level", OFS_LEVEL, 32'h00001005, 0);
		// Second pass is the back-to-back same-source case
		repeat (2) begin
			srcIn[7] <= 1'b1;
			waitq(0);
			rdc("ack7", OFS_IRQVEC, 32'h80020007, 0);
			rdc("svc", OFS_INSVC, 32'h24, 0);
			wr(OFS_IRQVEC, 32'h0);
			rdc("svcEoi", OFS_INSVC, 32'h20, 0);
			srcIn[7] <= 1'b0;
			tick(4);
		end
		maskIrq <= 1'b1;
		wr(12'h100, 32'h1);
		waitq(0);
		chk("masked", 0, irqEntry);
		rdc("ackDum", OFS_IRQVEC, 32'h80000000, 0);
		wr(12'h100, 32'h0);
		rdc("raw", 12'h100, 32'h0, 0);
		wr(OFS_IRQVEC, 32'h0);
		rdc("svcNest", OFS_INSVC, 32'h20, 0);
		maskIrq <= 1'b0;
		wr(OFS_IRQVEC, 32'h0);
		rdc("svcIdle", OFS_INSVC, 32'h0, 0);
		srcIn[9] <= 1'b1;
		waitq(1);
		chk("irqCalm", 0, irqReq);
		rdc("dbgF", OFS_FIQVEC, 32'h80010009, 1);
		tick(2);
		chk("fiqDbg", 1, fiqReq);
		rdc("ackF", OFS_FIQVEC, 32'h80010009, 0);
		rdc("svcF", OFS_INSVC, 32'h00020000, 0);
		chk("fiqAck", 0, fiqReq);
		wr(OFS_FIQVEC, 32'h0);
		rdc("stat", OFS_INTSTAT, 32'hf, 0);
		wr(OFS_IRQVEC, 32'h0);
		tick(2);
		chk("intOff", 0, interrupt);
		wr(OFS_INTMASK, 32'h10);
		tick(2);
		chk("intOn", 1, interrupt);
		wr(OFS_INTSTAT, 32'h10);
		tick(2);
		chk("intClr", 0, interrupt);
		rdc("stat2", OFS_INTSTAT, 32'hf, 0);
		conclude;
	end
	initial begin
		tick(4000);
		mismatches++;
		conclude;
	end
endmodule // vic_ctrl_bench
